// >>> rtl/rcs_top.sv
// Reset cause status register with Avalon-MM slave and interrupt
// Function
// (R1) Set config mismatch flag bit 9
// (R2) Bit 8 keeps regulator on in sleep
// (R3) Set pin reset flag bit 7
// (R4) Set software reset flag bit 6
// (R5) Set watchdog expiry flag bit 4
// (R6) Set sleep wake flag bit 3
// (R7) Set idle wake flag bit 2
// (R8) Set brownout flag bit 1, one at power-on
// (R9) Set power-on flag bit 0, one at power-on
// (R10) Software clears power-on and brownout after reading
// (R11) Flags hardware set, software writable, else zero
// (R12) Bits 31-10 and 5 read zero
// (R13) Hardware set wins over software clear
`timescale 1ns/100ps
module rcs_top (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [rcs_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic evt_config_mismatch,
  input wire logic evt_master_clear_pin,
  input wire logic evt_soft_reset,
  input wire logic evt_watchdog_timer,
  input wire logic evt_sleep_wake,
  input wire logic evt_idle_wake,
  input wire logic evt_brownout,
  input wire logic evt_power_on,
  output logic regulator_standby_keep_on,
  output logic irq
);
  import rcs_pkg::*;

  localparam int N_EVT = 8;
  localparam int EVT_BIT [N_EVT] = '{BIT_CMR, BIT_PIN, BIT_SW, BIT_WDT,
                                      BIT_SLEEP, BIT_IDLE, BIT_BOR, BIT_POR};

  logic [N_EVT-1:0] evt_raw;
  logic [N_EVT-1:0] evt_lvl;
  logic [N_EVT-1:0] evt_pulse;
  logic [9:0] set_vec;

  assign evt_raw = {evt_config_mismatch, evt_master_clear_pin,
                    evt_soft_reset, evt_watchdog_timer, evt_sleep_wake,
                    evt_idle_wake, evt_brownout, evt_power_on};

  // Event inputs arrive from outside this clock domain
  genvar gi;
  generate
    for (gi = 0; gi < N_EVT; gi++) begin : g_evt
      rcs_sync u_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .d_in(evt_raw[gi]),
        .q_out(evt_lvl[gi])
      );
      rcs_edge u_edge (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .lvl(evt_lvl[gi]),
        .pulse(evt_pulse[gi])
      );
    end
  endgenerate

  always_comb begin
    set_vec = 10'h000;
    for (int i = 0; i < N_EVT; i++) begin
      set_vec[EVT_BIT[i]] = evt_pulse[N_EVT-1-i];
    end
  end

  // Bus request decode; one wait cycle for reads and writes
  logic req;
  logic ack_ff;
  logic nxt_ack;
  logic hit_status;
  logic hit_irq;
  logic hit_mask;
  logic wr_lo;
  logic wr_hi;

  assign req = avs_read | avs_write;
  assign hit_status = (avs_address == OFF_STATUS);
  assign hit_irq = (avs_address == OFF_IRQ_STAT);
  assign hit_mask = (avs_address == OFF_IRQ_MASK);
  assign wr_lo = avs_write & ack_ff & avs_byteenable[0];
  assign wr_hi = avs_write & ack_ff & avs_byteenable[1];
  assign avs_waitrequest = req & ~ack_ff;

  always_comb begin
    nxt_ack = req & ~ack_ff;
  end

  // Status register with per-lane write
  logic [9:0] status_ff;
  logic [9:0] nxt_status;
  logic [9:0] irq_ff;
  logic [9:0] nxt_irq;
  logic [9:0] mask_ff;
  logic [9:0] nxt_mask;
  logic [9:0] wr_lane;

  assign wr_lane = {{2{wr_hi}}, {8{wr_lo}}};

  always_comb begin
    nxt_status = status_ff;
    if (hit_status) begin
      nxt_status = (status_ff & ~wr_lane) |
                   (avs_writedata[9:0] & wr_lane); // R11
    end
    nxt_status = (nxt_status | set_vec) & FLAG_MASK; // R13
    nxt_status[BIT_VREG] = status_ff[BIT_VREG]; // R2
    if (hit_status && wr_hi) begin
      nxt_status[BIT_VREG] = avs_writedata[BIT_VREG]; // R2
    end
  end

  always_comb begin
    nxt_irq = irq_ff;
    if (hit_irq) begin
      nxt_irq = irq_ff & ~(avs_writedata[9:0] & wr_lane);
    end
    nxt_irq = (nxt_irq | set_vec) & FLAG_MASK; // R13
    nxt_mask = mask_ff;
    if (hit_mask) begin
      nxt_mask = ((mask_ff & ~wr_lane) | (avs_writedata[9:0] & wr_lane))
                 & FLAG_MASK;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ack_ff <= 1'b0;
      status_ff <= RST_STATUS; // R8 R9 R11
      irq_ff <= RST_IRQ;
      mask_ff <= RST_MASK;
    end else begin
      ack_ff <= nxt_ack;
      status_ff <= nxt_status; // R1 R3 R4 R5 R6 R7 R8 R9
      irq_ff <= nxt_irq;
      mask_ff <= nxt_mask;
    end
  end

  // Read data registered at the wait cycle
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [1:0] resp_ff;
  logic [1:0] nxt_resp;

  always_comb begin
    nxt_rdata = rdata_ff;
    nxt_resp = 2'h0;
    if (req && !ack_ff) begin
      nxt_rdata = 32'h0;
      if (hit_status) begin
        nxt_rdata = {22'h0, status_ff}; // R12
      end else if (hit_irq) begin
        nxt_rdata = {22'h0, irq_ff};
      end else if (hit_mask) begin
        nxt_rdata = {22'h0, mask_ff};
      end else begin
        nxt_resp = 2'h2;
      end
    end else if (ack_ff) begin
      nxt_resp = resp_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= 32'h0;
      resp_ff <= 2'h0;
    end else begin
      rdata_ff <= nxt_rdata;
      resp_ff <= nxt_resp;
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_response = resp_ff;
  assign regulator_standby_keep_on = status_ff[BIT_VREG];
  assign irq = |(irq_ff & mask_ff);

  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    (status_ff & ~(FLAG_MASK | 10'h100)) == 10'h0) // R12
    else $error("reserved status bit set");

  a_set_wins: assert property (@(posedge clk_sys) disable iff (!nrst)
    evt_pulse[0] |=> status_ff[BIT_POR]) // R13
    else $error("power-on event lost");

  a_wdt_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    evt_pulse[4] |=> status_ff[BIT_WDT]) // R5
    else $error("watchdog flag not set");

  a_cmr_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(evt_lvl[7]) |=> status_ff[BIT_CMR]) // R1
    else $error("mismatch flag not set");

  a_pin_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    evt_pulse[6] |=> status_ff[BIT_PIN]) // R3
    else $error("pin flag not set");

  a_sw_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    evt_pulse[5] |=> status_ff[BIT_SW]) // R4
    else $error("soft flag not set");

  a_sleep_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
    evt_pulse[3] && evt_pulse[2] |=> status_ff[BIT_SLEEP] &&
    status_ff[BIT_IDLE]) // R6 R7
    else $error("wake flag not set");

  a_bor_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    evt_pulse[1] |=> status_ff[BIT_BOR]) // R8
    else $error("brownout flag not set");

  a_vreg_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    !(avs_write && hit_status) |=> $stable(regulator_standby_keep_on)) // R2
    else $error("regulator bit changed");

  a_flag_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    !(avs_write && hit_status) && status_ff[BIT_POR]
    |=> status_ff[BIT_POR]) // R11
    else $error("flag cleared without write");

  // Bus handshake: one wait cycle, then a single ack
  a_wait_first: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    req && !ack_ff |-> avs_waitrequest)
    else $error("no wait on new request");

  a_ack_follow: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    req && !ack_ff |=> ack_ff)
    else $error("ack missing after wait");

  a_ack_single: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    ack_ff |=> !ack_ff)
    else $error("ack held too long");

  a_ack_idle: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    !req |=> !ack_ff)
    else $error("ack without request");

  a_idle_nowait: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    !req |-> !avs_waitrequest)
    else $error("wait while idle");

  // Read data and response
  a_rdata_status: assert property (@(posedge clk_sys) // R11
    disable iff (!nrst)
    avs_read && hit_status && !ack_ff |=>
    avs_readdata == {22'h0, $past(status_ff)})
    else $error("status read data wrong");

  a_rdata_irq: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    avs_read && hit_irq && !ack_ff |=> avs_readdata == {22'h0, $past(irq_ff)})
    else $error("irq status read data wrong");

  a_rdata_mask: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    avs_read && hit_mask && !ack_ff |=> avs_readdata == {22'h0, $past(mask_ff)})
    else $error("mask read data wrong");

  a_rd_unmapped: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    req && !ack_ff && !(hit_status || hit_irq || hit_mask) |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");

  a_rdata_upper: assert property (@(posedge clk_sys) // R12
    disable iff (!nrst)
    avs_readdata[31:10] == 22'h0 && !avs_readdata[5])
    else $error("unimplemented bits read nonzero");

  a_rdata_hold: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    !(req && !ack_ff) |=> avs_readdata == $past(avs_readdata))
    else $error("read data changed while idle");

  a_resp_unmapped: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    req && !ack_ff && !(hit_status || hit_irq || hit_mask) |=> avs_response == 2'h2)
    else $error("unmapped response missing");

  a_resp_mapped: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    req && !ack_ff && (hit_status || hit_irq || hit_mask) |=> avs_response == 2'h0)
    else $error("mapped response not okay");

  // Register state and interrupt
  a_irq_set: assert property (@(posedge clk_sys) // R5
    disable iff (!nrst)
    set_vec[BIT_WDT] && mask_ff[BIT_WDT] && !(avs_write && hit_mask) |=> irq)
    else $error("unmasked event without irq");

  a_irq_clear: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    wr_lo && hit_irq && avs_writedata[BIT_WDT] && !set_vec[BIT_WDT] |=> !irq_ff[BIT_WDT])
    else $error("irq status not cleared");

  a_irq_sticky: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    irq_ff[BIT_PIN] && !(avs_write && hit_irq) |=> irq_ff[BIT_PIN])
    else $error("irq status lost");

  a_vreg_write: assert property (@(posedge clk_sys) // R2
    disable iff (!nrst)
    wr_hi && hit_status |=> regulator_standby_keep_on == $past(avs_writedata[BIT_VREG]))
    else $error("regulator bit not written");

  a_cmr_clear: assert property (@(posedge clk_sys) // R11
    disable iff (!nrst)
    wr_hi && hit_status && !avs_writedata[BIT_CMR] && !set_vec[BIT_CMR] |=> !status_ff[BIT_CMR])
    else $error("mismatch flag not cleared");

  a_status_hold: assert property (@(posedge clk_sys) // R11
    disable iff (!nrst)
    !(avs_write && hit_status) && set_vec == 10'h0 |=> status_ff == $past(status_ff))
    else $error("status changed without cause");

  a_mask_hold: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    !(avs_write && hit_mask) |=> mask_ff == $past(mask_ff))
    else $error("mask changed without write");

  a_sleep_set: assert property (@(posedge clk_sys) // R6
    disable iff (!nrst)
    evt_pulse[3] |=> status_ff[BIT_SLEEP])
    else $error("sleep flag not set");

  a_idle_set: assert property (@(posedge clk_sys) // R7
    disable iff (!nrst)
    evt_pulse[2] |=> status_ff[BIT_IDLE])
    else $error("idle flag not set");

  a_por_irq: assert property (@(posedge clk_sys) // R9
    disable iff (!nrst)
    evt_pulse[0] |=> irq_ff[BIT_POR])
    else $error("power-on irq status not set");

  a_bor_irq: assert property (@(posedge clk_sys) // R8
    disable iff (!nrst)
    evt_pulse[1] |=> irq_ff[BIT_BOR])
    else $error("brownout irq status not set");
endmodule

// >>> pkg/rcs_pkg.sv
// Package for the reset cause status register block
package rcs_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'h8;
  localparam int BIT_CMR = 9;
  localparam int BIT_VREG = 8;
  localparam int BIT_PIN = 7;
  localparam int BIT_SW = 6;
  localparam int BIT_WDT = 4;
  localparam int BIT_SLEEP = 3;
  localparam int BIT_IDLE = 2;
  localparam int BIT_BOR = 1;
  localparam int BIT_POR = 0;
  localparam logic [9:0] FLAG_MASK = 10'h2df;
  localparam logic [9:0] RST_STATUS = 10'h003;
  localparam logic [9:0] RST_IRQ = 10'h000;
  localparam logic [9:0] RST_MASK = 10'h000;
  localparam int SYNC_N = 3;
endpackage

// >>> rtl/rcs_sync.sv
// Three-stage synchroniser with second/third agreement
`timescale 1ns/100ps
module rcs_sync (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic d_in,
  output logic q_out
);
  logic [2:0] stage_ff;
  logic [2:0] nxt_stage;
  logic q_ff;
  logic nxt_q;
  always_comb begin
    nxt_stage = {stage_ff[1:0], d_in};
    nxt_q = q_ff;
    if (stage_ff[1] == stage_ff[2]) begin
      nxt_q = stage_ff[2];
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stage_ff <= 3'h0;
      q_ff <= 1'b0;
    end else begin
      stage_ff <= nxt_stage;
      q_ff <= nxt_q;
    end
  end
  assign q_out = q_ff;
endmodule

// >>> rtl/rcs_edge.sv
// Rising-edge pulse from a synchronised level
`timescale 1ns/100ps
module rcs_edge (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic lvl,
  output logic pulse
);
  logic prev_ff;
  logic nxt_prev;
  always_comb begin
    nxt_prev = lvl;
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= nxt_prev;
    end
  end
  assign pulse = lvl & ~prev_ff;
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for the reset cause status register block
`timescale 1ns/100ps
module tb_top;
  import rcs_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  logic [7:0] evt = 8'h00;
  logic regulator_standby_keep_on;
  logic irq;
  logic wq_s, irq_s, keep_s;
  logic [31:0] rd_s;
  logic [1:0] rsp_s;
  logic [31:0] rd;
  int errors = 0;
  int total_checks = 0;
  int bit_tab [8] = '{BIT_CMR, BIT_PIN, BIT_SW, BIT_WDT, BIT_SLEEP,
                      BIT_IDLE, BIT_BOR, BIT_POR};

  rcs_top i_rcs_top (
    .clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .evt_config_mismatch(evt[0]),
    .evt_master_clear_pin(evt[1]), .evt_soft_reset(evt[2]),
    .evt_watchdog_timer(evt[3]), .evt_sleep_wake(evt[4]),
    .evt_idle_wake(evt[5]), .evt_brownout(evt[6]),
    .evt_power_on(evt[7]),
    .regulator_standby_keep_on(regulator_standby_keep_on), .irq(irq));

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  // Outputs are steady at the falling edge, seen as sampled at next rise
  always @(negedge clk_sys) begin
    wq_s <= avs_waitrequest;
    rd_s <= avs_readdata;
    rsp_s <= avs_response;
    irq_s <= irq;
    keep_s <= regulator_standby_keep_on;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon transfer; request held until waitrequest seen low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd, output logic [31:0] d);
    int n;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (wq_s === 1'b0) break;
    end
    if (n == 20) begin
      errors++;
      print_verdict();
    end
    d = rd_s;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic pulse(input int i);
    evt[i] <= 1'b1;
    repeat (6) @(posedge clk_sys);
    evt[i] <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic t_reset();
    bus(1'b0, OFF_STATUS, 32'h0, rd);
    chk(rd, 32'h0000_0003);
    chk({31'h0, keep_s}, 32'h0);
    bus(1'b0, OFF_IRQ_STAT, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'b0, OFF_IRQ_MASK, 32'h0, rd);
    chk(rd, 32'h0);
    chk({31'h0, irq_s}, 32'h0);
  endtask

  task automatic t_rw();
    bus(1'b1, OFF_STATUS, 32'hffff_ffff, rd);
    bus(1'b0, OFF_STATUS, 32'h0, rd);
    chk(rd, 32'h0000_03df);
    chk({31'h0, keep_s}, 32'h1);
    bus(1'b1, OFF_STATUS, 32'h0, rd);
    bus(1'b0, OFF_STATUS, 32'h0, rd);
    chk(rd, 32'h0);
    chk({31'h0, keep_s}, 32'h0);
  endtask

  task automatic t_events();
    bus(1'b1, OFF_IRQ_MASK, 32'h0000_02df, rd);
    for (int i = 0; i < 8; i++) begin
      pulse(i);
      bus(1'b0, OFF_STATUS, 32'h0, rd);
      chk(rd, 32'h1 << bit_tab[i]);
      bus(1'b0, OFF_IRQ_STAT, 32'h0, rd);
      chk(rd, 32'h1 << bit_tab[i]);
      chk({31'h0, irq_s}, 32'h1);
      bus(1'b1, OFF_STATUS, 32'h0, rd);
      bus(1'b1, OFF_IRQ_STAT, 32'h1 << bit_tab[i], rd);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, irq_s}, 32'h0);
    end
    // Masked event: flag recorded, no interrupt
    bus(1'b1, OFF_IRQ_MASK, 32'h0, rd);
    pulse(3);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq_s}, 32'h0);
    bus(1'b0, OFF_STATUS, 32'h0, rd);
    chk(rd, 32'h1 << BIT_WDT);
    bus(1'b1, OFF_IRQ_STAT, 32'h0000_03ff, rd);
    bus(1'b1, OFF_STATUS, 32'h0, rd);
  endtask

  task automatic t_unmapped();
    bus(1'b1, 4'hc, 32'hffff_ffff, rd);
    chk({30'h0, rsp_s}, 32'h2);
    bus(1'b0, 4'hc, 32'h0, rd);
    chk(rd, 32'h0);
    chk({30'h0, rsp_s}, 32'h2);
    bus(1'b0, OFF_STATUS, 32'h0, rd);
    chk(rd, 32'h0);
    chk({30'h0, rsp_s}, 32'h0);
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_rw();
    t_events();
    t_unmapped();
    print_verdict();
  end
endmodule
